// file: design/ict_pkg.sv
// Shared constants and types of the instruction cycle timing sequencer.
// Assumes one 125 MHz clock and an asynchronous active-low reset.
package ict_pkg;

    // Clock and bus cycle timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int BUS_CLOCKS = 4;
    localparam int IACK_CLOCKS = 4;
    localparam int WAIT_PHASE = 2;
    localparam int PHASE_W = $clog2(BUS_CLOCKS);

    // Counter widths and register count limit
    localparam int CNT_W = 9;
    localparam int BUSN_W = 6;
    localparam int REGN_W = 5;
    localparam int MAX_REGS = 16;
    localparam int SYNC_STAGES = 2;

    // Instruction classes and exceptions that get timed
    typedef enum logic [4:0] {
        OP_JUMP, OP_CALL, OP_ADDR_LOAD, OP_ADDR_PUSH, OP_MULTI_REG_MOVE,
        OP_ADD_EXTENDED, OP_SUB_EXTENDED, OP_DECIMAL_ADD, OP_DECIMAL_SUB,
        OP_MEM_COMPARE, OP_PERIPHERAL_MOVE, OP_LOGIC_STATUS_WORD,
        OP_LOGIC_COND_CODE_BYTE, OP_EXT_RESET, OP_EXCEPTION_RETURN,
        OP_RESTORE_RETURN, OP_SUBROUTINE_RETURN, OP_STOP,
        EXC_BUS_ERROR, EXC_ADDR_ERROR, EXC_ILLEGAL, EXC_PRIVILEGE, EXC_TRACE,
        EXC_TRAP, EXC_BOUNDS_CHECK, EXC_DIVIDE_ZERO, EXC_OVERFLOW_TRAP,
        EXC_INTERRUPT, EXC_RESET
    } ict_op_t;

    // Effective addressing modes of the operand
    typedef enum logic [3:0] {
        AM_REG, AM_IND, AM_POSTINC, AM_PREDEC, AM_DISP, AM_INDEX,
        AM_ABS_W, AM_ABS_L, AM_PC_DISP, AM_PC_INDEX
    } ict_mode_t;

    // Sequencer states
    typedef enum logic [1:0] {ST_HOLD, ST_IDLE, ST_LOAD, ST_RUN} ict_state_t;

    // One timing entry: clocks(reads/writes), validity and address add flag
    typedef struct packed {
        logic ok;
        logic add_ea;
        logic [CNT_W-1:0] clocks;
        logic [BUSN_W-1:0] reads;
        logic [BUSN_W-1:0] writes;
    } ict_entry_t;

    localparam ict_entry_t ENTRY_NONE = '0;
    localparam logic [PHASE_W-1:0] PHASE_RESET = '0;
    localparam logic [CNT_W-1:0] CNT_RESET = '0;
    localparam logic [BUSN_W-1:0] BUSN_RESET = '0;

endpackage

// file: design/ict_bus_if.sv
// Handshake between the sequencer and its bus cycle timer.
// Assumes both ends run on the same clock.
interface ict_bus_if;
    logic go;
    logic is_write;
    logic wait_req;
    logic abort;
    logic take;
    logic active;
    logic done;
    logic done_write;

    modport seq (output go, is_write, wait_req, abort, input take, active, done, done_write);
    modport cyc (input go, is_write, wait_req, abort, output take, active, done, done_write);
endinterface

// file: design/ict_sync.sv
// Two-stage synchroniser for a group of asynchronous pin levels.
// Assumes the pins are levels that stay put for several clocks.
module ict_sync import ict_pkg::*; #(
    parameter int W = 3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic [W-1:0] pin_in,
    input wire logic [W-1:0] rst_val,
    output logic [W-1:0] pin_sync
);
    typedef struct packed {
        logic [W-1:0] first;
        logic [W-1:0] second;
    } ict_sync_t;

    ict_sync_t s_reg;
    ict_sync_t s_next;

    // Each bit passes two flops; only the second stage is read
    always_comb begin
        s_next = s_reg;
        s_next.first = pin_in;
        s_next.second = s_reg.first;
    end

    // Registers come up all ones: negated for the active-low pins, asserted for the wait pin
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '1;
        end else begin
            s_reg <= s_next;
        end
    end

    // The reset value has no effect: each bit is the second stage level unchanged
    genvar i;
    generate
        for (i = 0; i < W; i++) begin : g_bit
            assign pin_sync[i] = s_reg.second[i] & (rst_val[i] | s_reg.second[i]);
        end
    endgenerate
endmodule

// file: design/ict_buscyc.sv
// Timer for one bus read or write cycle of four periods plus wait states.
// Assumes the request comes from logic on the same clock.
module ict_buscyc import ict_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    ict_bus_if.cyc bus
);
    typedef struct packed {
        logic active;
        logic is_write;
        logic [PHASE_W-1:0] phase;
    } ict_cyc_t;

    ict_cyc_t s_reg;
    ict_cyc_t s_next;
    logic last;

    // Last period of a cycle; a new cycle may start right behind it
    assign last = s_reg.active && (s_reg.phase == PHASE_W'(BUS_CLOCKS - 1));
    assign bus.take = bus.go && (!s_reg.active || last) && !bus.abort;
    assign bus.active = s_reg.active;
    assign bus.done = last;
    assign bus.done_write = s_reg.is_write;

    // Phase walk with wait states held in the third period
    always_comb begin
        s_next = s_reg;
        if (bus.abort) begin
            s_next.active = 1'b0;
            s_next.phase = PHASE_RESET;
        end else if (bus.take) begin
            s_next.active = 1'b1;
            s_next.is_write = bus.is_write;
            s_next.phase = PHASE_RESET;
        end else if (last) begin
            s_next.active = 1'b0;
        end else if (s_reg.active) begin
            if (!(s_reg.phase == PHASE_W'(WAIT_PHASE) && bus.wait_req)) begin
                s_next.phase = s_reg.phase + 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule

// file: design/ict_timing.sv
// Instruction cycle timing sequencer: plays out each instruction or exception
// as bus read cycles, bus write cycles and bus-idle internal clocks.
// Assumes the decoder supplies class, mode, size and address times on start.

// What this block does
// - Each instruction is timed as total clocks, bus reads and bus writes.
// - A bus cycle lasts four clocks; wait states stretch it and the total.
// - Entries marked address-dependent add the address calculation's clocks and reads.
// - Register-indirect jump 8(2/0), call 16(2/2), address load 4(1/0).
// - Address push 12(1/2) register-indirect, 20(3/2) absolute long.
// - Multi-register move scales with register count n, word or long.
// - Multi-register move rejects postincrement/PC modes outbound and predecrement inbound.
// - Index register size never changes execution time.
// - Extended add/sub long register 8(1/0); memory 18(3/1) or 30(5/2).
// - Decimal add/sub register 6(1/0); memory compare 12(3/0) or 20(5/0).
// - Peripheral move inbound 16(4/0) or 24(6/0); outbound long 24(2/4).
// - Logic immediate to status or condition byte 20(3/0); reset instruction 132(1/0).
// - Exception return 20(5/0), subroutine return 16(4/0), stop 4(0/0).
// - Exception time covers stacking, vector fetch and first handler fetch.
// - Bus/address error 50(4/7); illegal, privilege, trace, trap 34(4/3); bounds 40+.
// - Interrupt takes 44(5/3) with a four-clock acknowledge cycle.
// - Reset exception 40(6/0), counted from reset and halt first seen negated.
module ict_timing import ict_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire ict_op_t op,
    input wire ict_mode_t mode,
    input wire logic long_size,
    input wire logic to_memory,
    input wire logic [REGN_W-1:0] reg_count,
    input wire logic [CNT_W-1:0] ea_clocks,
    input wire logic [BUSN_W-1:0] ea_reads,
    input wire logic reset_pin_n,
    input wire logic halt_pin_n,
    input wire logic mem_wait_pin,
    output logic seq_busy,
    output logic reset_exc,
    output logic bus_read,
    output logic bus_write,
    output logic internal_op,
    output logic instr_done,
    output logic bad_mode,
    output logic [CNT_W-1:0] total_clocks,
    output logic [BUSN_W-1:0] total_reads,
    output logic [BUSN_W-1:0] total_writes
);
    typedef struct packed {
        ict_state_t state;
        ict_op_t op;
        ict_mode_t mode;
        logic long_sz;
        logic to_mem;
        logic [REGN_W-1:0] regs;
        logic [CNT_W-1:0] ea_c;
        logic [BUSN_W-1:0] ea_r;
        logic [BUSN_W-1:0] rd_left;
        logic [BUSN_W-1:0] wr_left;
        logic [CNT_W-1:0] idle_left;
        logic [CNT_W-1:0] elapsed;
        logic [BUSN_W-1:0] rd_cnt;
        logic [BUSN_W-1:0] wr_cnt;
        logic busy;
        logic rst_exc;
        logic bus_rd;
        logic bus_wr;
        logic internal;
        logic done;
        logic bad;
        logic [CNT_W-1:0] tot_c;
        logic [BUSN_W-1:0] tot_r;
        logic [BUSN_W-1:0] tot_w;
    } ict_seq_t;

    ict_seq_t s_reg;
    ict_seq_t s_next;
    ict_bus_if bus_if();
    ict_entry_t ent;
    logic [CNT_W-1:0] ent_c;
    logic [BUSN_W-1:0] ent_r;
    logic [BUSN_W:0] bus_n;
    logic [CNT_W-1:0] idle_c;
    logic [BUSN_W-1:0] cur_rd;
    logic [BUSN_W-1:0] cur_wr;
    logic [2:0] pins_sync;
    logic rst_ok;
    logic halt_ok;

    // Builds one table entry
    function automatic ict_entry_t mk(input int c, input int r, input int w, input logic ea);
        ict_entry_t e;
        e.ok = 1'b1;
        e.add_ea = ea;
        e.clocks = CNT_W'(c);
        e.reads = BUSN_W'(r);
        e.writes = BUSN_W'(w);
        return e;
    endfunction

    // Control-flow class by mode: index modes time the same for any index size
    function automatic ict_entry_t flow_entry(input ict_op_t o, input ict_mode_t m);
        ict_entry_t jump_op;
        ict_entry_t addr_load_op;
        ict_entry_t e;
        jump_op = ENTRY_NONE;
        addr_load_op = ENTRY_NONE;
        case (m)
            AM_IND: begin
                jump_op = mk(8, 2, 0, 1'b0);
                addr_load_op = mk(4, 1, 0, 1'b0);
            end
            AM_DISP, AM_ABS_W, AM_PC_DISP: begin
                jump_op = mk(10, 2, 0, 1'b0);
                addr_load_op = mk(8, 2, 0, 1'b0);
            end
            AM_INDEX, AM_PC_INDEX: begin
                jump_op = mk(14, 3, 0, 1'b0);
                addr_load_op = mk(12, 2, 0, 1'b0);
            end
            AM_ABS_L: begin
                jump_op = mk(12, 3, 0, 1'b0);
                addr_load_op = mk(12, 3, 0, 1'b0);
            end
            default: begin
                jump_op = ENTRY_NONE;
                addr_load_op = ENTRY_NONE;
            end
        endcase
        e = addr_load_op;
        case (o)
            OP_JUMP: e = jump_op;
            OP_CALL: begin
                // Call pushes the return address: eight more clocks, two writes
                e = jump_op;
                e.clocks = jump_op.clocks + CNT_W'(8);
                e.reads = (addr_load_op.reads < BUSN_W'(2)) ? BUSN_W'(2) : addr_load_op.reads;
                e.writes = BUSN_W'(2);
            end
            OP_ADDR_PUSH: begin
                e.clocks = addr_load_op.clocks + CNT_W'(8);
                e.writes = BUSN_W'(2);
            end
            default: e = addr_load_op;
        endcase
        if (!addr_load_op.ok) begin
            e = ENTRY_NONE;
        end
        return e;
    endfunction

    // Multi-register move: base by mode, then four or eight clocks per register
    function automatic ict_entry_t multi_entry(input ict_mode_t m, input logic lng,
                                               input logic tomem, input logic [REGN_W-1:0] n);
        ict_entry_t e;
        logic [CNT_W-1:0] per;
        logic [BUSN_W-1:0] nb;
        per = lng ? CNT_W'(n) * CNT_W'(8) : CNT_W'(n) * CNT_W'(4);
        nb = lng ? BUSN_W'(n) * BUSN_W'(2) : BUSN_W'(n);
        case (m)
            AM_IND, AM_POSTINC, AM_PREDEC: e = mk(8, 2, 0, 1'b0);
            AM_DISP, AM_ABS_W, AM_PC_DISP: e = mk(12, 3, 0, 1'b0);
            AM_INDEX, AM_PC_INDEX: e = mk(14, 3, 0, 1'b0);
            AM_ABS_L: e = mk(16, 4, 0, 1'b0);
            default: e = ENTRY_NONE;
        endcase
        e.clocks = e.clocks + per;
        if (tomem) begin
            e.writes = nb;
            if (m == AM_POSTINC || m == AM_PC_DISP || m == AM_PC_INDEX) begin
                e = ENTRY_NONE;
            end
        end else begin
            // Inbound moves add a prefetch of four clocks and one read
            e.clocks = e.clocks + CNT_W'(BUS_CLOCKS);
            e.reads = e.reads + BUSN_W'(1) + nb;
            if (m == AM_PREDEC) begin
                e = ENTRY_NONE;
            end
        end
        if (m == AM_REG || n > REGN_W'(MAX_REGS)) begin
            e = ENTRY_NONE;
        end
        return e;
    endfunction

    // Full timing table
    function automatic ict_entry_t lookup(input ict_op_t o, input ict_mode_t m, input logic lng,
                                          input logic tomem, input logic [REGN_W-1:0] n);
        ict_entry_t e;
        logic reg_form;
        reg_form = (m == AM_REG);
        e = ENTRY_NONE;
        case (o)
            OP_JUMP, OP_CALL, OP_ADDR_LOAD, OP_ADDR_PUSH: e = flow_entry(o, m);
            OP_MULTI_REG_MOVE: e = multi_entry(m, lng, tomem, n);
            OP_ADD_EXTENDED, OP_SUB_EXTENDED: begin
                if (reg_form) begin
                    e = lng ? mk(8, 1, 0, 1'b0) : mk(4, 1, 0, 1'b0);
                end else begin
                    e = lng ? mk(30, 5, 2, 1'b0) : mk(18, 3, 1, 1'b0);
                end
            end
            OP_DECIMAL_ADD, OP_DECIMAL_SUB: begin
                e = reg_form ? mk(6, 1, 0, 1'b0) : mk(18, 3, 1, 1'b0);
            end
            OP_MEM_COMPARE: begin
                e = lng ? mk(20, 5, 0, 1'b0) : mk(12, 3, 0, 1'b0);
                if (reg_form) begin
                    e = ENTRY_NONE;
                end
            end
            OP_PERIPHERAL_MOVE: begin
                if (tomem) begin
                    e = lng ? mk(24, 2, 4, 1'b0) : mk(16, 2, 2, 1'b0);
                end else begin
                    e = lng ? mk(24, 6, 0, 1'b0) : mk(16, 4, 0, 1'b0);
                end
            end
            OP_LOGIC_STATUS_WORD, OP_LOGIC_COND_CODE_BYTE: e = mk(20, 3, 0, 1'b0);
            OP_EXT_RESET: e = mk(132, 1, 0, 1'b0);
            OP_EXCEPTION_RETURN: e = mk(20, 5, 0, 1'b0);
            OP_RESTORE_RETURN: e = mk(20, 2, 0, 1'b0);
            OP_SUBROUTINE_RETURN: e = mk(16, 4, 0, 1'b0);
            OP_STOP: e = mk(4, 0, 0, 1'b0);
            EXC_BUS_ERROR, EXC_ADDR_ERROR: e = mk(50, 4, 7, 1'b0);
            EXC_ILLEGAL, EXC_PRIVILEGE, EXC_TRACE, EXC_TRAP: e = mk(34, 4, 3, 1'b0);
            EXC_BOUNDS_CHECK: e = mk(40, 4, 3, 1'b1);
            EXC_DIVIDE_ZERO: e = mk(38, 4, 3, 1'b1);
            EXC_OVERFLOW_TRAP: e = mk(34, 5, 3, 1'b0);
            EXC_INTERRUPT: e = mk(40 + IACK_CLOCKS, 5, 3, 1'b0);
            EXC_RESET: e = mk(40, 6, 0, 1'b0);
            default: e = ENTRY_NONE;
        endcase
        return e;
    endfunction

    // Pins from outside pass two flops first
    ict_sync #(.W(3)) u_sync (
        .clk(clk),
        .nrst(nrst),
        .pin_in({mem_wait_pin, halt_pin_n, reset_pin_n}),
        .rst_val(3'h7),
        .pin_sync(pins_sync)
    );
    assign rst_ok = pins_sync[0];
    assign halt_ok = pins_sync[1];

    ict_buscyc u_buscyc (
        .clk(clk),
        .nrst(nrst),
        .bus(bus_if)
    );

    // Entry of the latched request, with address time added where marked
    assign ent = lookup(s_reg.op, s_reg.mode, s_reg.long_sz, s_reg.to_mem, s_reg.regs);
    assign ent_c = ent.add_ea ? CNT_W'(ent.clocks + s_reg.ea_c) : ent.clocks;
    assign ent_r = ent.add_ea ? BUSN_W'(ent.reads + s_reg.ea_r) : ent.reads;
    assign bus_n = (BUSN_W + 1)'(ent_r) + (BUSN_W + 1)'(ent.writes);
    assign idle_c = CNT_W'(ent_c - CNT_W'(bus_n) * CNT_W'(BUS_CLOCKS));

    // Bus requests: all reads first, then writes, back to back
    assign cur_rd = (s_reg.state == ST_LOAD) ? ent_r : s_reg.rd_left;
    assign cur_wr = (s_reg.state == ST_LOAD) ? ent.writes : s_reg.wr_left;
    assign bus_if.go = ((s_reg.state == ST_LOAD && ent.ok) || s_reg.state == ST_RUN)
                       && (cur_rd != BUSN_RESET || cur_wr != BUSN_RESET);
    assign bus_if.is_write = (cur_rd == BUSN_RESET);
    assign bus_if.wait_req = pins_sync[2];
    assign bus_if.abort = !rst_ok;

    // Sequencer
    always_comb begin
        s_next = s_reg;
        s_next.done = 1'b0;
        s_next.bad = 1'b0;
        if (bus_if.take) begin
            if (cur_rd != BUSN_RESET) begin
                s_next.rd_left = cur_rd - BUSN_W'(1);
                s_next.wr_left = cur_wr;
            end else begin
                s_next.rd_left = cur_rd;
                s_next.wr_left = cur_wr - BUSN_W'(1);
            end
        end
        case (s_reg.state)
            ST_HOLD: begin
                s_next.busy = 1'b1;
                s_next.rst_exc = 1'b1;
                if (rst_ok && halt_ok) begin
                    s_next.op = EXC_RESET;
                    s_next.mode = AM_REG;
                    s_next.ea_c = CNT_RESET;
                    s_next.ea_r = BUSN_RESET;
                    s_next.state = ST_LOAD;
                end
            end
            ST_IDLE: begin
                if (start) begin
                    s_next.op = op;
                    s_next.mode = mode;
                    s_next.long_sz = long_size;
                    s_next.to_mem = to_memory;
                    s_next.regs = reg_count;
                    s_next.ea_c = ea_clocks;
                    s_next.ea_r = ea_reads;
                    s_next.busy = 1'b1;
                    s_next.state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (!ent.ok) begin
                    s_next.bad = 1'b1;
                    s_next.busy = 1'b0;
                    s_next.rst_exc = 1'b0;
                    s_next.state = ST_IDLE;
                end else begin
                    s_next.idle_left = idle_c;
                    s_next.elapsed = CNT_RESET;
                    s_next.rd_cnt = BUSN_RESET;
                    s_next.wr_cnt = BUSN_RESET;
                    s_next.state = ST_RUN;
                end
            end
            ST_RUN: begin
                s_next.elapsed = s_reg.elapsed + CNT_W'(1);
                if (bus_if.done && bus_if.done_write) begin
                    s_next.wr_cnt = s_reg.wr_cnt + BUSN_W'(1);
                end else if (bus_if.done) begin
                    s_next.rd_cnt = s_reg.rd_cnt + BUSN_W'(1);
                end
                // Idle clocks run once the bus cycles are over
                if (!bus_if.active && !bus_if.go && s_reg.idle_left != CNT_RESET) begin
                    s_next.idle_left = s_reg.idle_left - CNT_W'(1);
                end
                if ((bus_if.done && !bus_if.take && s_reg.rd_left == BUSN_RESET
                     && s_reg.wr_left == BUSN_RESET && s_reg.idle_left == CNT_RESET)
                    || (!bus_if.active && !bus_if.go && s_reg.idle_left == CNT_W'(1))) begin
                    s_next.done = 1'b1;
                    s_next.tot_c = s_reg.elapsed + CNT_W'(1);
                    s_next.tot_r = s_next.rd_cnt;
                    s_next.tot_w = s_next.wr_cnt;
                    s_next.busy = 1'b0;
                    s_next.rst_exc = 1'b0;
                    s_next.state = ST_IDLE;
                end
            end
            default: s_next.state = ST_HOLD;
        endcase
        // Reset pin asserted again: drop everything and wait for negation
        if (!rst_ok) begin
            s_next.state = ST_HOLD;
            s_next.busy = 1'b1;
            s_next.rst_exc = 1'b1;
            s_next.done = 1'b0;
            s_next.bad = 1'b0;
        end
        // Bus activity levels line up with the timer's cycles
        if (bus_if.take) begin
            s_next.bus_rd = !bus_if.is_write;
            s_next.bus_wr = bus_if.is_write;
        end else if (bus_if.done || !rst_ok) begin
            s_next.bus_rd = 1'b0;
            s_next.bus_wr = 1'b0;
        end
        s_next.internal = (s_next.state == ST_RUN) && !s_next.bus_rd && !s_next.bus_wr;
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_reg <= '0;
            s_reg.state <= ST_HOLD;
            s_reg.busy <= 1'b1;
            s_reg.rst_exc <= 1'b1;
        end else begin
            s_reg <= s_next;
        end
    end

    assign seq_busy = s_reg.busy;
    assign reset_exc = s_reg.rst_exc;
    assign bus_read = s_reg.bus_rd;
    assign bus_write = s_reg.bus_wr;
    assign internal_op = s_reg.internal;
    assign instr_done = s_reg.done;
    assign bad_mode = s_reg.bad;
    assign total_clocks = s_reg.tot_c;
    assign total_reads = s_reg.tot_r;
    assign total_writes = s_reg.tot_w;
endmodule

// file: verification/ict_timing_asserts.sv
// Concurrent checks on the timing sequencer's outputs.
// Assumes binding to the top module; one clock, async active-low reset.
module ict_timing_asserts import ict_pkg::*; (
    input wire logic clk,
    input wire logic nrst,
    input wire logic start,
    input wire ict_op_t op,
    input wire logic seq_busy,
    input wire logic bus_read,
    input wire logic bus_write,
    input wire logic internal_op,
    input wire logic instr_done,
    input wire logic bad_mode,
    input wire logic [CNT_W-1:0] total_clocks,
    input wire logic [BUSN_W-1:0] total_reads,
    input wire logic [BUSN_W-1:0] total_writes
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (!nrst);
    // Bus cycle shape and an idle bus outside instructions
    a_bus_excl: assert property (!(bus_read && bus_write)) else $error("read and write overlap");
    a_idle_quiet: assert property (!seq_busy |-> !(bus_read || bus_write || internal_op))
        else $error("bus activity while idle");
    a_read_len: assert property ($rose(bus_read) |=> bus_read [*3]) else $error("short read");
    a_write_len: assert property ($rose(bus_write) |=> bus_write [*3]) else $error("short write");
    // Request acceptance, completion pulse and held totals
    a_start_load: assert property (start && !seq_busy |=> seq_busy) else $error("start lost");
    a_done_idle: assert property (instr_done |-> !seq_busy ##1 !instr_done)
        else $error("done pulse wrong");
    a_totals_hold: assert property (!instr_done |-> $stable({total_clocks, total_reads, total_writes}))
        else $error("totals moved");
    a_done_sum: assert property (instr_done |-> total_clocks >=
        (CNT_W'(total_reads) + CNT_W'(total_writes)) * 9'h004) else $error("clocks below bus time");
    a_stop_time: assert property (start && !seq_busy && op == OP_STOP |-> ##6
        (instr_done && total_clocks == 9'h004 && total_reads == 6'h00)) else $error("stop timing");
    a_bad_quiet: assert property (bad_mode |-> !instr_done && !bus_read && !bus_write)
        else $error("refused entry ran");
endmodule

bind ict_timing ict_timing_asserts u_asserts (.clk, .nrst, .start, .op, .seq_busy, .bus_read,
    .bus_write, .internal_op, .instr_done, .bad_mode, .total_clocks, .total_reads, .total_writes);

// file: verification/ict_mem_model.sv
// Memory and peripheral bus model: answers every bus cycle, slowly on request.
// Assumes the sequencer's bus_read and bus_write levels on the shared clock.
module ict_mem_model (
    input wire logic clk,
    input wire logic nrst,
    input wire logic bus_read,
    input wire logic bus_write,
    input wire logic wait_on,
    output logic mem_wait_pin
);
    logic [2:0] left_reg = 3'h0;
    logic act_reg = 1'b0;
    // Holds off for six clocks at each new burst while wait_on is set, so a slow answer always ends
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            left_reg <= 3'h0;
            act_reg <= 1'b0;
        end else begin
            act_reg <= bus_read | bus_write;
            if (wait_on && (bus_read | bus_write) && !act_reg) left_reg <= 3'h6;
            else if (left_reg != 3'h0) left_reg <= left_reg - 3'h1;
        end
    end
    // Wait level, high while the hold-off count is nonzero
    assign mem_wait_pin = (left_reg != 3'h0);
endmodule

// file: verification/ict_timing_tb_top.sv
// Self-checking bench of the instruction cycle timing sequencer.
// Assumes the bus model drives the wait pin; 125 MHz clock.
module ict_timing_tb_top import ict_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, nrst = 1'b0, start = 1'b0, long_size = 1'b0, to_memory = 1'b0;
    logic reset_pin_n = 1'b1, halt_pin_n = 1'b1, wait_on = 1'b0, mem_wait_pin;
    ict_op_t op = OP_STOP;
    ict_mode_t mode = AM_REG;
    logic [REGN_W-1:0] reg_count = '0;
    logic [CNT_W-1:0] ea_clocks = '0, total_clocks;
    logic [BUSN_W-1:0] ea_reads = '0, total_reads, total_writes;
    logic seq_busy, reset_exc, bus_read, bus_write, internal_op, instr_done, bad_mode;
    int num_errors = 0, checks = 0;
    ict_timing DUT (.clk, .nrst, .start, .op, .mode, .long_size, .to_memory, .reg_count,
        .ea_clocks, .ea_reads, .reset_pin_n, .halt_pin_n, .mem_wait_pin, .seq_busy, .reset_exc,
        .bus_read, .bus_write, .internal_op, .instr_done, .bad_mode, .total_clocks,
        .total_reads, .total_writes);
    ict_mem_model MEM (.clk, .nrst, .bus_read, .bus_write, .wait_on, .mem_wait_pin);
    // Free-running clock
    initial begin
        forever #4 clk = ~clk;
    end
    task automatic fail(string msg);
        num_errors++;
        $display("[ERR] %0t %s", $time, msg);
    endtask
    task automatic complete_run;
        if (num_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // One request (reset starts by itself), then judge the triple
    task automatic chk(ict_op_t o, int c, int r, int w, ict_mode_t m = AM_REG,
        logic l = 1'b0, logic t = 1'b0, int n = 0);
        int i;
        if (o != EXC_RESET) begin
            @(posedge clk);
            start <= 1'b1;
            op <= o;
            mode <= m;
            long_size <= l;
            to_memory <= t;
            reg_count <= REGN_W'(n);
            @(posedge clk);
            start <= 1'b0;
        end
        for (i = 0; i < 400 && instr_done !== 1'b1 && bad_mode !== 1'b1; i++) begin
            @(posedge clk);
            #1;
        end
        checks++;
        if (i == 400) begin
            fail("no completion");
            complete_run();
        end
        if (bad_mode !== (c == 0)) fail("refusal mismatch");
        else if (c != 0 && ($isunknown(total_clocks) || total_clocks < CNT_W'(c + int'(wait_on))
            || total_clocks > CNT_W'(c + 16 * int'(wait_on)) || total_reads !== BUSN_W'(r)
            || total_writes !== BUSN_W'(w))) fail("timing triple mismatch");
    endtask
    task automatic t_flow;
        chk(OP_JUMP, 8, 2, 0, AM_IND);
        chk(OP_CALL, 16, 2, 2, AM_IND);
        chk(OP_ADDR_LOAD, 4, 1, 0, AM_IND);
        chk(OP_ADDR_PUSH, 12, 1, 2, AM_IND);
        chk(OP_ADDR_PUSH, 20, 3, 2, AM_ABS_L);
        chk(OP_JUMP, 14, 3, 0, AM_INDEX, 1'b1);
    endtask
    task automatic t_multi;
        chk(OP_MULTI_REG_MOVE, 24, 6, 0, AM_IND, 1'b0, 1'b0, 3);
        chk(OP_MULTI_REG_MOVE, 16, 2, 2, AM_PREDEC, 1'b0, 1'b1, 2);
        chk(OP_MULTI_REG_MOVE, 140, 3, 32, AM_DISP, 1'b1, 1'b1, 16);
        chk(OP_MULTI_REG_MOVE, 0, 0, 0, AM_POSTINC, 1'b0, 1'b1, 1);
        chk(OP_MULTI_REG_MOVE, 0, 0, 0, AM_PC_DISP, 1'b0, 1'b1, 1);
        chk(OP_MULTI_REG_MOVE, 0, 0, 0, AM_PREDEC, 1'b0, 1'b0, 1);
    endtask
    task automatic t_misc;
        chk(OP_ADD_EXTENDED, 8, 1, 0, AM_REG, 1'b1);
        chk(OP_SUB_EXTENDED, 18, 3, 1, AM_PREDEC);
        chk(OP_ADD_EXTENDED, 30, 5, 2, AM_PREDEC, 1'b1);
        chk(OP_DECIMAL_SUB, 6, 1, 0);
        chk(OP_MEM_COMPARE, 20, 5, 0, AM_POSTINC, 1'b1);
        chk(OP_PERIPHERAL_MOVE, 16, 4, 0, AM_DISP);
        chk(OP_PERIPHERAL_MOVE, 24, 2, 4, AM_DISP, 1'b1, 1'b1);
        chk(OP_LOGIC_COND_CODE_BYTE, 20, 3, 0);
        chk(OP_EXT_RESET, 132, 1, 0);
        chk(OP_EXCEPTION_RETURN, 20, 5, 0);
        chk(OP_SUBROUTINE_RETURN, 16, 4, 0);
        chk(OP_STOP, 4, 0, 0);
    endtask
    task automatic t_exc;
        chk(EXC_ADDR_ERROR, 50, 4, 7);
        chk(EXC_PRIVILEGE, 34, 4, 3);
        chk(EXC_INTERRUPT, 44, 5, 3);
        @(posedge clk);
        ea_clocks <= 9'h008;
        ea_reads <= 6'h02;
        chk(EXC_BOUNDS_CHECK, 48, 6, 3, AM_IND);
        chk(EXC_TRACE, 34, 4, 3);
    endtask
    task automatic t_pin;
        @(posedge clk);
        reset_pin_n <= 1'b0;
        repeat (5) @(posedge clk);
        if (reset_exc !== 1'b1) fail("no hold");
        reset_pin_n <= 1'b1;
        chk(EXC_RESET, 40, 6, 0);
    endtask
    task automatic t_wait;
        @(posedge clk);
        wait_on <= 1'b1;
        chk(OP_CALL, 16, 2, 2, AM_IND);
    endtask
    // Reset two cycles, then every scenario
    initial begin
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        chk(EXC_RESET, 40, 6, 0);
        t_flow();
        t_multi();
        t_misc();
        t_exc();
        t_pin();
        t_wait();
        complete_run();
    end
endmodule
